// *** pkg/tmd_pkg.sv ***
package tmd_pkg;

	// Opcode prefixes, matched against the top bits of the 16-bit instruction word.
	localparam logic [7:0] OPC_TA_IMM = 8'h10;
	localparam logic [7:0] OPC_TB_IMM = 8'h11;
	localparam logic [8:0] OPC_TA_LO = 9'h028;
	localparam logic [8:0] OPC_TA_HI = 9'h029;
	localparam logic [8:0] OPC_TB_LO = 9'h02A;
	localparam logic [8:0] OPC_TB_HI = 9'h02B;
	localparam logic [4:0] OPC_WR_LD = 5'h1D;
	localparam logic [4:0] OPC_IND_RD = 5'h19;
	localparam logic [4:0] OPC_IND_WR = 5'h1B;
	localparam logic [7:0] OPC_PAGE = 8'h5D;
	localparam logic [8:0] OPC_CARRY_RD = 9'h0B2;

	// Instruction field positions.
	localparam int IMM_LSB = 0;
	localparam int ADR_LSB = 0;
	localparam int WSEL_LSB = 7;

	// Register offsets on the AHB-Lite slave.
	localparam logic [7:0] A_STATUS = 8'h00;
	localparam logic [7:0] A_TIMER = 8'h04;
	localparam logic [7:0] A_RAM_ADDR = 8'h08;
	localparam logic [7:0] A_RAM_DATA = 8'h0C;

	localparam logic [3:0] NIB_ZERO = 4'h0;
	localparam logic [7:0] BYTE_ZERO = 8'h00;
	localparam logic [6:0] ADDR_ZERO = 7'h00;
	localparam logic [31:0] WORD_ZERO = 32'h0000_0000;
	localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
	localparam logic [2:0] HWR_PAD = 3'h0;

	typedef enum logic [3:0] {
		OP_NONE, OP_TA_IMM, OP_TB_IMM, OP_TA_LO, OP_TA_HI, OP_TB_LO, OP_TB_HI,
		OP_WR_LD, OP_IND_RD, OP_IND_WR, OP_PAGE, OP_CARRY_RD
	} tmd_op_t;

	typedef enum logic {ST_IDLE, ST_IND} tmd_state_t;

	typedef struct packed {
		logic [7:0] count;
		logic [3:0] preset_hi;
		logic [3:0] preset_lo;
		logic start;
	} tmd_timer_t;

endpackage : tmd_pkg

// *** core/tmd_decoder.sv ***
// Functional notes
// - Timer A immediate load, start, one cycle
// - Memory nibble to timer A low preset
// - Prefix decodes timer A high preset write
// - Opcode loads and starts timer B
// - Prefix decodes timer B low preset write
// - Prefix decodes timer B high preset write
// - Memory nibble into selected working register
// - Paged indirect read, two cycles
// - Paged indirect write, two cycles
// - Memory nibble into page_select, one cycle
// - Carry into bit 0, zero_flag updated
`timescale 1ns/1ps
module tmd_decoder
(
	input wire logic mclk_i,
	input wire logic srst_i,
	input wire logic instr_valid_i,
	input wire logic [15:0] instr_i,
	output logic instr_ready_o,
	output logic done_o,
	input wire logic carry_flag_i,
	output logic zero_flag_o,
	output logic [3:0] acc_o,
	output logic [3:0] page_select_o,
	output tmd_pkg::tmd_timer_t timer_a_o,
	output tmd_pkg::tmd_timer_t timer_b_o,
	input wire logic hsel_i,
	input wire logic [31:0] haddr_i,
	input wire logic [1:0] htrans_i,
	input wire logic hwrite_i,
	input wire logic [2:0] hsize_i,
	input wire logic hready_i,
	input wire logic [31:0] hwdata_i,
	output logic [31:0] hrdata_o,
	output logic hreadyout_o,
	output logic hresp_o
);
	import tmd_pkg::*;
	localparam logic [2:0] HSIZE_WORD = 3'h2;

	logic [3:0] ram_mem [0:127];
	tmd_state_t state_reg;
	tmd_op_t op_d;
	logic accept;
	logic [6:0] r_addr;
	logic [3:0] mem_r;
	logic [6:0] ptr_reg;
	logic [3:0] wsel_reg;
	logic ind_wr_reg;
	logic done_reg;
	logic zero_reg;
	logic [3:0] acc_reg;
	logic [3:0] page_reg;
	tmd_timer_t ta_reg;
	tmd_timer_t tb_reg;
	logic core_we;
	logic [6:0] core_wa;
	logic [3:0] core_wd;
	logic ap_valid_reg;
	logic ap_write_reg;
	logic [7:0] ap_addr_reg;
	logic [6:0] bus_ram_addr_reg;
	logic [31:0] hrdata_reg;
	logic bus_ram_wr;

	function automatic tmd_op_t decode(input logic [15:0] ins);
		tmd_op_t op;
		op = OP_NONE;
		if (ins[15:8] == OPC_TA_IMM)
			op = OP_TA_IMM;
		else if (ins[15:8] == OPC_TB_IMM)
			op = OP_TB_IMM;
		else if (ins[15:7] == OPC_TA_LO)
			op = OP_TA_LO;
		else if (ins[15:7] == OPC_TA_HI)
			op = OP_TA_HI;
		else if (ins[15:7] == OPC_TB_LO)
			op = OP_TB_LO;
		else if (ins[15:7] == OPC_TB_HI)
			op = OP_TB_HI;
		else if (ins[15:11] == OPC_WR_LD)
			op = OP_WR_LD;
		else if (ins[15:11] == OPC_IND_RD)
			op = OP_IND_RD;
		else if (ins[15:11] == OPC_IND_WR)
			op = OP_IND_WR;
		else if (ins[15:8] == OPC_PAGE)
			op = OP_PAGE;
		else if (ins[15:7] == OPC_CARRY_RD)
			op = OP_CARRY_RD;
		return op;
	endfunction : decode

	function automatic logic [6:0] wr_addr(input logic [3:0] wsel);
		return {HWR_PAD, wsel};
	endfunction : wr_addr

	assign accept = instr_valid_i && (state_reg == ST_IDLE);
	assign op_d = decode(instr_i);
	assign r_addr = instr_i[ADR_LSB +: 7];
	assign mem_r = ram_mem[r_addr];
	assign instr_ready_o = (state_reg == ST_IDLE);

	// Indirect transfers read the pointer nibble in the first cycle and move data in the second.
	always_ff @(posedge mclk_i)
	begin
		if (srst_i)
		begin
			state_reg <= ST_IDLE;
			ptr_reg <= ADDR_ZERO;
			wsel_reg <= NIB_ZERO;
			ind_wr_reg <= 1'b0;
		end
		else if (state_reg == ST_IND)
			state_reg <= ST_IDLE;
		else if (accept && (op_d == OP_IND_RD || op_d == OP_IND_WR))
		begin
			state_reg <= ST_IND;
			ptr_reg <= {page_reg[2:0], mem_r};
			wsel_reg <= instr_i[WSEL_LSB +: 4];
			ind_wr_reg <= (op_d == OP_IND_WR);
		end
	end

	always_ff @(posedge mclk_i)
	begin
		if (srst_i)
			done_reg <= 1'b0;
		else
			done_reg <= (accept && op_d != OP_IND_RD && op_d != OP_IND_WR) || (state_reg == ST_IND);
	end

	// Every write into data memory from an instruction goes through this one port.
	always_comb
	begin
		core_we = 1'b0;
		core_wa = r_addr;
		core_wd = mem_r;
		if (state_reg == ST_IND)
		begin
			core_we = 1'b1;
			if (ind_wr_reg)
			begin
				core_wa = ptr_reg;
				core_wd = ram_mem[wr_addr(wsel_reg)];
			end
			else
			begin
				core_wa = wr_addr(wsel_reg);
				core_wd = ram_mem[ptr_reg];
			end
		end
		else if (accept && op_d == OP_WR_LD)
		begin
			core_we = 1'b1;
			core_wa = wr_addr(instr_i[WSEL_LSB +: 4]);
			core_wd = mem_r;
		end
		else if (accept && op_d == OP_CARRY_RD)
		begin
			core_we = 1'b1;
			core_wd = {HWR_PAD, carry_flag_i};
		end
	end

	// The bus is stalled rather than dropped when it would collide with an instruction write.
	assign bus_ram_wr = ap_valid_reg && ap_write_reg && (ap_addr_reg == A_RAM_DATA);

	always_ff @(posedge mclk_i)
	begin
		if (core_we)
			ram_mem[core_wa] <= core_wd;
		else if (bus_ram_wr)
			ram_mem[bus_ram_addr_reg] <= hwdata_i[3:0];
	end

	always_ff @(posedge mclk_i)
	begin
		if (srst_i)
		begin
			acc_reg <= NIB_ZERO;
			zero_reg <= 1'b1;
		end
		else if (accept && op_d == OP_CARRY_RD)
		begin
			acc_reg <= {HWR_PAD, carry_flag_i};
			zero_reg <= !carry_flag_i;
		end
	end

	always_ff @(posedge mclk_i)
	begin
		if (srst_i)
			page_reg <= NIB_ZERO;
		else if (accept && op_d == OP_PAGE)
			page_reg <= mem_r;
	end

	always_ff @(posedge mclk_i)
	begin
		if (srst_i)
			ta_reg <= '0;
		else
		begin
			ta_reg.start <= 1'b0;
			if (accept && op_d == OP_TA_IMM)
			begin
				ta_reg.count <= instr_i[IMM_LSB +: 8];
				ta_reg.preset_hi <= instr_i[IMM_LSB + 4 +: 4];
				ta_reg.preset_lo <= instr_i[IMM_LSB +: 4];
				ta_reg.start <= 1'b1;
			end
			else if (accept && op_d == OP_TA_LO)
				ta_reg.preset_lo <= mem_r;
			else if (accept && op_d == OP_TA_HI)
				ta_reg.preset_hi <= mem_r;
		end
	end

	always_ff @(posedge mclk_i)
	begin
		if (srst_i)
			tb_reg <= '0;
		else
		begin
			tb_reg.start <= 1'b0;
			if (accept && op_d == OP_TB_IMM)
			begin
				tb_reg.count <= instr_i[IMM_LSB +: 8];
				tb_reg.preset_hi <= instr_i[IMM_LSB + 4 +: 4];
				tb_reg.preset_lo <= instr_i[IMM_LSB +: 4];
				tb_reg.start <= 1'b1;
			end
			else if (accept && op_d == OP_TB_LO)
				tb_reg.preset_lo <= mem_r;
			else if (accept && op_d == OP_TB_HI)
				tb_reg.preset_hi <= mem_r;
		end
	end

	always_ff @(posedge mclk_i)
	begin
		if (srst_i)
		begin
			ap_valid_reg <= 1'b0;
			ap_write_reg <= 1'b0;
			ap_addr_reg <= BYTE_ZERO;
		end
		else if (hready_i)
		begin
			ap_valid_reg <= hsel_i && (htrans_i == HTRANS_NONSEQ) && (hsize_i == HSIZE_WORD);
			ap_write_reg <= hwrite_i;
			ap_addr_reg <= haddr_i[7:0];
		end
	end

	always_ff @(posedge mclk_i)
	begin
		if (srst_i)
			bus_ram_addr_reg <= ADDR_ZERO;
		else if (hreadyout_o && ap_valid_reg && ap_write_reg && ap_addr_reg == A_RAM_ADDR)
			bus_ram_addr_reg <= hwdata_i[6:0];
	end

	// Read data is captured at the address phase, so a read answers with no wait state.
	always_ff @(posedge mclk_i)
	begin
		if (srst_i)
			hrdata_reg <= WORD_ZERO;
		else if (hready_i && hsel_i && htrans_i == HTRANS_NONSEQ && hsize_i == HSIZE_WORD && !hwrite_i)
		begin
			case (haddr_i[7:0])
				A_STATUS: hrdata_reg <= {22'h000000, page_reg, acc_reg, !instr_ready_o, zero_reg};
				A_TIMER: hrdata_reg <= {8'h00, tb_reg.preset_hi, tb_reg.preset_lo, ta_reg.preset_hi,
					ta_reg.preset_lo, ta_reg.count};
				A_RAM_ADDR: hrdata_reg <= {25'h0000000, bus_ram_addr_reg};
				A_RAM_DATA: hrdata_reg <= {28'h0000000, ram_mem[bus_ram_addr_reg]};
				default: hrdata_reg <= WORD_ZERO;
			endcase
		end
	end

	assign hreadyout_o = !(bus_ram_wr && core_we);
	assign hresp_o = 1'b0;
	assign hrdata_o = hrdata_reg;
	assign done_o = done_reg;
	assign zero_flag_o = zero_reg;
	assign acc_o = acc_reg;
	assign page_select_o = page_reg;
	assign timer_a_o = ta_reg;
	assign timer_b_o = tb_reg;

	default clocking cb @(posedge mclk_i); endclocking
	default disable iff (srst_i);

	property p_ta_imm;
		accept && op_d == OP_TA_IMM |=> ta_reg.start && ta_reg.count == $past(instr_i[7:0])
			##1 (!ta_reg.start || $past(accept && op_d == OP_TA_IMM));
	endproperty
	a_ta_imm: assert property (p_ta_imm) else $error("Timer A immediate load failed.");

	property p_ta_lo;
		accept && op_d == OP_TA_LO |=> ta_reg.preset_lo == $past(mem_r) && done_reg;
	endproperty
	a_ta_lo: assert property (p_ta_lo) else $error("Timer A low preset write failed.");

	property p_ta_hi;
		accept && instr_i[15:7] == OPC_TA_HI |=> ta_reg.preset_hi == $past(mem_r);
	endproperty
	a_ta_hi: assert property (p_ta_hi) else $error("Timer A high preset write failed.");

	property p_tb_imm;
		accept && instr_i[15:8] == OPC_TB_IMM |=> tb_reg.start && tb_reg.count == $past(instr_i[7:0]);
	endproperty
	a_tb_imm: assert property (p_tb_imm) else $error("Timer B immediate load failed.");

	property p_tb_nib;
		accept && instr_i[15:8] == 8'h15 |=> (($past(instr_i[7]) ? tb_reg.preset_hi : tb_reg.preset_lo)
			== $past(mem_r));
	endproperty
	a_tb_nib: assert property (p_tb_nib) else $error("Timer B preset nibble write failed.");

	property p_wr_ld;
		accept && op_d == OP_WR_LD |=> ram_mem[$past(wr_addr(instr_i[10:7]))] == $past(mem_r);
	endproperty
	a_wr_ld: assert property (p_wr_ld) else $error("Working register load failed.");

	property p_ind_rd;
		accept && op_d == OP_IND_RD |=> !instr_ready_o ##1 instr_ready_o && done_reg
			&& ram_mem[$past(wr_addr(instr_i[10:7]), 2)] == $past(ram_mem[ptr_reg]);
	endproperty
	a_ind_rd: assert property (p_ind_rd) else $error("Indirect read failed.");

	property p_ind_wr;
		accept && op_d == OP_IND_WR |=> ptr_reg == $past({page_reg[2:0], mem_r}) && !instr_ready_o
			##1 done_reg && ram_mem[$past(ptr_reg)] == $past(ram_mem[wr_addr(wsel_reg)]);
	endproperty
	a_ind_wr: assert property (p_ind_wr) else $error("Indirect write failed.");

	property p_page;
		accept && op_d == OP_PAGE |=> page_reg == $past(mem_r);
	endproperty
	a_page: assert property (p_page) else $error("Page select write failed.");

	property p_carry_rd;
		accept && op_d == OP_CARRY_RD |=> acc_reg == {HWR_PAD, $past(carry_flag_i)}
			&& zero_reg == !$past(carry_flag_i)
			&& ram_mem[$past(r_addr)] == {HWR_PAD, $past(carry_flag_i)};
	endproperty
	a_carry_rd: assert property (p_carry_rd) else $error("Carry read failed.");

	property p_flags_kept;
		!(accept && op_d == OP_CARRY_RD) |=> $stable(zero_reg) && $stable(acc_reg);
	endproperty
	a_flags_kept: assert property (p_flags_kept) else $error("Flag changed unexpectedly.");

endmodule : tmd_decoder

// *** dv/tmd_tb_top.sv ***
`timescale 1ns/1ps
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin miscompares++; \
	$display("[ERR] %0t got %h exp %h", $time, (a), (b)); end end
module timer_and_indirect_move_decode_tb_top;
	import tmd_pkg::*;
	logic mclk_i, srst_i, instr_valid_i, carry_flag_i, hsel_i, hwrite_i, hready_i, cb;
	logic [15:0] instr_i;
	logic [31:0] haddr_i, hwdata_i, hrdata_o, x;
	logic [1:0] htrans_i;
	logic [2:0] hsize_i;
	logic instr_ready_o, done_o, zero_flag_o, hreadyout_o, hresp_o;
	logic [3:0] acc_o, page_select_o, w, v, v2, lo, p, n;
	logic [6:0] r, q, tgt;
	logic [7:0] d;
	logic [8:0] nop [4];
	tmd_timer_t timer_a_o, timer_b_o, t;
	int miscompares = 0;
	int num_checks = 0;

	// The single slave closes the bus, so its ready is the bus ready.
	assign hready_i = hreadyout_o;

	tmd_decoder i_dut
	(
		.mclk_i(mclk_i), .srst_i(srst_i), .instr_valid_i(instr_valid_i), .instr_i(instr_i),
		.instr_ready_o(instr_ready_o), .done_o(done_o), .carry_flag_i(carry_flag_i),
		.zero_flag_o(zero_flag_o), .acc_o(acc_o), .page_select_o(page_select_o),
		.timer_a_o(timer_a_o), .timer_b_o(timer_b_o), .hsel_i(hsel_i), .haddr_i(haddr_i),
		.htrans_i(htrans_i), .hwrite_i(hwrite_i), .hsize_i(hsize_i), .hready_i(hready_i),
		.hwdata_i(hwdata_i), .hrdata_o(hrdata_o), .hreadyout_o(hreadyout_o), .hresp_o(hresp_o)
	);

	initial
	begin
		mclk_i = 1'b0;
		forever #2 mclk_i = ~mclk_i;
	end

	task automatic wrap_up;
		if (miscompares == 0 && num_checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : wrap_up

	// The low three page bits pick a block of sixteen nibbles for indirect moves.
	function automatic logic [6:0] ind_addr(input logic [3:0] pg, input logic [3:0] nib);
		return {pg[2:0], nib};
	endfunction : ind_addr

	task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd);
		@(posedge mclk_i);
		hsel_i <= 1'b1;
		htrans_i <= HTRANS_NONSEQ;
		haddr_i <= {24'h000000, a};
		hwrite_i <= wr;
		do @(posedge mclk_i); while (hready_i !== 1'b1);
		hsel_i <= 1'b0;
		htrans_i <= 2'h0;
		hwdata_i <= wd;
		do @(posedge mclk_i); while (hready_i !== 1'b1);
		rd = hrdata_o;
		`CHK(hresp_o, 1'b0)
	endtask : ahb

	task automatic ram_wr(input logic [6:0] a, input logic [3:0] dv);
		logic [31:0] y;
		ahb(1'b1, A_RAM_ADDR, {25'h0, a}, y);
		ahb(1'b1, A_RAM_DATA, {28'h0, dv}, y);
	endtask : ram_wr

	task automatic ram_rd(input logic [6:0] a, output logic [3:0] dv);
		logic [31:0] y;
		ahb(1'b1, A_RAM_ADDR, {25'h0, a}, y);
		ahb(1'b0, A_RAM_DATA, WORD_ZERO, y);
		dv = y[3:0];
	endtask : ram_rd

	// Returns in the cycle where done is high, so one-cycle results are visible to the caller.
	task automatic exec(input logic [15:0] ins, input int cyc);
		int k;
		@(posedge mclk_i);
		instr_valid_i <= 1'b1;
		instr_i <= ins;
		@(posedge mclk_i);
		instr_valid_i <= 1'b0;
		#1;
		k = 1;
		if (cyc == 2) `CHK(instr_ready_o, 1'b0)
		while (done_o !== 1'b1 && k < 4)
		begin
			@(posedge mclk_i);
			#1;
			k++;
		end
		`CHK(k, cyc)
	endtask : exec

	initial
	begin
		#80000;
		miscompares++;
		wrap_up();
	end

	initial
	begin
		srst_i = 1'b1;
		instr_valid_i = 1'b0;
		instr_i = 16'h0000;
		carry_flag_i = 1'b0;
		hsel_i = 1'b0;
		hwrite_i = 1'b0;
		haddr_i = WORD_ZERO;
		hwdata_i = WORD_ZERO;
		htrans_i = 2'h0;
		hsize_i = 3'h2;
		nop = '{OPC_TA_LO, OPC_TA_HI, OPC_TB_LO, OPC_TB_HI};
		void'($urandom(32'hFB753690));
		repeat (5) @(posedge mclk_i);
		srst_i <= 1'b0;
		for (int c = 0; c < 2; c++)
		begin
			cb = c[0];
			r = 7'($urandom_range(127, 16));
			ram_wr(r, 4'hF);
			carry_flag_i <= cb;
			exec({OPC_CARRY_RD, r}, 1);
			`CHK(acc_o, {3'h0, cb})
			`CHK(zero_flag_o, ~cb)
			ram_rd(r, n);
			`CHK(n, {3'h0, cb})
			ahb(1'b0, A_STATUS, WORD_ZERO, x);
			`CHK(x[9:0], {4'h0, 3'h0, cb, 1'b0, ~cb})
		end
		for (int i = 0; i < 2; i++)
		begin
			d = 8'($urandom);
			exec({(i == 0) ? OPC_TA_IMM : OPC_TB_IMM, d}, 1);
			t = (i == 0) ? timer_a_o : timer_b_o;
			`CHK(t.count, d)
			`CHK(t.start, 1'b1)
		end
		`CHK(timer_a_o.start, 1'b0)
		for (int i = 0; i < 4; i++)
		begin
			r = 7'($urandom_range(127, 16));
			v = 4'($urandom);
			ram_wr(r, v);
			exec({nop[i], r}, 1);
			t = (i < 2) ? timer_a_o : timer_b_o;
			`CHK(i[0] ? t.preset_hi : t.preset_lo, v)
		end
		w = 4'($urandom);
		r = 7'($urandom_range(127, 16));
		v = 4'($urandom);
		ram_wr(r, v);
		exec({OPC_WR_LD, w, r}, 1);
		ram_rd({3'h0, w}, n);
		`CHK(n, v)
		repeat (4)
		begin
			// Pointer, page source and target are kept apart so no write clobbers another.
			p = {1'($urandom), 3'($urandom_range(7, 1))};
			lo = 4'($urandom);
			tgt = ind_addr(p, lo);
			r = tgt ^ 7'h01;
			q = tgt ^ 7'h02;
			w = 4'($urandom);
			ram_wr(q, p);
			exec({OPC_PAGE, 1'($urandom), q}, 1);
			`CHK(page_select_o, p)
			v = 4'($urandom);
			ram_wr(r, lo);
			ram_wr(tgt, v);
			exec({OPC_IND_RD, w, r}, 2);
			ram_rd({3'h0, w}, n);
			`CHK(n, v)
			v2 = ~v;
			ram_wr({3'h0, w}, v2);
			exec({OPC_IND_WR, w, r}, 2);
			ram_rd(tgt, n);
			`CHK(n, v2)
		end
		`CHK(zero_flag_o, 1'b0)
		ahb(1'b0, 8'h40, WORD_ZERO, x);
		`CHK(x, WORD_ZERO)
		wrap_up();
	end
endmodule : timer_and_indirect_move_decode_tb_top
